// file: tb/pin_port_model.sv
// general purpose port pins seen by the pin interrupt unit
`timescale 1ns/1ps
module pin_port_model (
  input  wire logic       pclk,
  input  wire logic [1:0] port_sel,
  input  wire logic [7:0] level,
  output logic      [7:0] port0_pins,
  output logic      [7:0] port1_pins,
  output logic      [7:0] port2_pins,
  output logic      [7:0] port3_pins
);
  logic [7:0] drv [4];
  initial foreach (drv[i]) drv[i] = 8'h00;
  // unselected ports carry the inverse level
  always @(posedge pclk) foreach (drv[i])
    drv[i] <= (i == port_sel) ? level : ~level;
  assign port0_pins = drv[0];
  assign port1_pins = drv[1];
  assign port2_pins = drv[2];
  assign port3_pins = drv[3];
endmodule

// file: tb/tb_pin_change_interrupt_unit.sv
// self-checking bench of the pin change interrupt unit
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t value mismatch", $time); end end
module tb_pin_change_interrupt_unit import pin_irq_pkg::*; ;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  apb_req_s    req     = '0;
  logic [1:0]  psrc    = 2'h0;
  logic [7:0]  lvl     = 8'h00;
  logic [31:0] seed    = 32'h4855966b;
  int          n_errors = 0;
  int          num_checks = 0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, pin_irq, irq, er;
  logic [7:0]  p0, p1, p2, p3, ctrl, pe, ne, r, em;

  always #12.5 pclk = ~pclk;

  pin_change_interrupt_unit dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pins(p0), .port1_pins(p1), .port2_pins(p2), .port3_pins(p3),
    .pin_irq(pin_irq), .irq(irq));
  pin_port_model pins_far (.pclk(pclk), .port_sel(psrc), .level(lvl),
    .port0_pins(p0), .port1_pins(p1), .port2_pins(p2), .port3_pins(p3));

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  // channels in edge mode for a control value
  function automatic logic [7:0] edge_mask(input logic [7:0] c);
    return {c[7], c[7], c[6], c[6], c[5:2]};
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, wd}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      report_and_stop();
    end
    rdv = prdata;
    er = pslverr;
    req <= '0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rdv, {24'h0, exp})
  endtask

  task automatic pins(input logic [1:0] s, input logic [7:0] v);
    @(posedge pclk);
    psrc <= s;
    lvl <= v;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_CTRL, 8'h00);
    rdchk(IDX_NEG_EN, 8'h00);
    rdchk(IDX_POS_EN, 8'h00);
    rdchk(IDX_FLAGS, 8'hff);
    `CHK(pin_irq, 1'b1)
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      apb(1'b1, IDX_CTRL, 8'(s));
      pins(2'(s), r);
      rdchk(IDX_FLAGS, ~r);
      apb(1'b1, IDX_FLAGS, r);
      rdchk(IDX_FLAGS, ~r);
    end
    for (int k = 0; k < 8; k++) begin
      ctrl = (k == 0) ? 8'hfc : (k == 1) ? 8'h80 : (k == 2) ? 8'h40
             : rnd() & 8'hfc;
      pe = rnd();
      ne = rnd();
      r = rnd();
      em = edge_mask(ctrl);
      apb(1'b1, IDX_CTRL, ctrl);
      apb(1'b1, IDX_POS_EN, pe);
      apb(1'b1, IDX_NEG_EN, ne);
      pins(2'h0, 8'h00);
      apb(1'b1, IDX_FLAGS, 8'h00);
      rdchk(IDX_FLAGS, ~em);
      `CHK(pin_irq, (~em != 8'h00))
      pins(2'h0, r);
      rdchk(IDX_FLAGS, (em & r & pe) | (~em & ~r));
      pins(2'h0, 8'h00);
      rdchk(IDX_FLAGS, (em & r & (pe | ne)) | ~em);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_CTRL, 8'h00);
    rdchk(IDX_NEG_EN, 8'h00);
    rdchk(IDX_POS_EN, 8'h00);
    rdchk(IDX_FLAGS, 8'hff);
    apb(1'b1, IDX_CTRL, 8'hfc);
    apb(1'b1, IDX_FLAGS, 8'h5a);
    rdchk(IDX_FLAGS, 8'h5a);
    apb(1'b1, IDX_FLAGS, 8'h00);
    rdchk(IDX_FLAGS, 8'h00);
    `CHK(pin_irq, 1'b0)
    apb(1'b1, IDX_POS_EN, 8'h01);
    apb(1'b1, IDX_NEG_EN, 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    apb(1'b0, IDX_IRQ_STAT, 8'h00);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    pins(2'h0, 8'h01);
    `CHK(irq, 1'b1)
    rdchk(IDX_IRQ_STAT, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, IDX_IRQ_MASK, 8'h00);
    pins(2'h0, 8'h00);
    pins(2'h0, 8'h01);
    `CHK(irq, 1'b0)
    rdchk(IDX_IRQ_STAT, 8'h01);
    apb(1'b0, 8'h10, 8'h00);
    `CHK(er, 1'b1)
    `CHK(rdv, 32'h0)
    report_and_stop();
  end
endmodule

// file: verilog/pin_change_interrupt_unit.sv
// pin change interrupt unit with apb register slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module pin_change_interrupt_unit
  import pin_irq_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire apb_req_s          apb_req,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        port0_pins,
  input  wire logic [7:0]        port1_pins,
  input  wire logic [7:0]        port2_pins,
  input  wire logic [7:0]        port3_pins,
  output logic                   pin_irq,
  output logic                   irq
);

  pin_irq_type_port_ctrl_s ctrl_q;
  logic [7:0]              neg_en_q;
  logic [7:0]              pos_en_q;
  logic [7:0]              flag_q;
  logic [7:0]              flag_d;
  logic [7:0]              pin_q;
  logic [7:0]              pin_prev_q;
  logic                    pin_valid_q;
  logic [7:0]              irq_stat_q;
  logic [7:0]              irq_mask_q;
  logic [DATA_W-1:0]       prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    pin_irq_q;
  logic                    irq_q;
  logic                    pin_seen_q;
  logic [7:0]              irq_stat_d;
  logic [7:0]              irq_mask_d;

  logic [7:0]              edge_mode;
  logic [7:0]              fall_hit;
  logic [7:0]              rise_hit;
  logic [7:0]              edge_hit;
  logic [7:0]              level_hit;
  logic                    access;
  logic                    done;
  logic                    wr_done;
  logic                    rd_done;
  logic [7:0]              idx;
  logic                    aligned;
  logic                    mapped;
  logic [7:0]              rd_byte;
  logic [7:0]              stat_hit;

  // picks the port that feeds the channels
  function automatic logic [7:0] port_mux(
    input logic [1:0] sel,
    input logic [7:0] p0,
    input logic [7:0] p1,
    input logic [7:0] p2,
    input logic [7:0] p3
  );
    logic [7:0] r;
    r = p0;
    unique case (sel)
      2'h0: r = p0;
      2'h1: r = p1;
      2'h2: r = p2;
      2'h3: r = p3;
    endcase
    return r;
  endfunction

  // per channel detection type, 1 means edge
  function automatic logic [7:0] type_vec(
    input pin_irq_type_port_ctrl_s c
  );
    logic [7:0] t;
    t = {c.type_sel_ch6_ch7, c.type_sel_ch6_ch7,
         c.type_sel_ch4_ch5, c.type_sel_ch4_ch5,
         c.type_sel_ch3_ch0};
    return t;
  endfunction

  function automatic logic is_reg(
    input logic [7:0] i
  );
    logic r;
    r = (i == IDX_CTRL) || (i == IDX_NEG_EN) || (i == IDX_POS_EN) ||
        (i == IDX_FLAGS) || (i == IDX_IRQ_STAT) || (i == IDX_IRQ_MASK);
    return r;
  endfunction

  // bus decode
  assign access  = apb_req.psel && apb_req.penable;
  assign done    = access && pready_q;
  assign wr_done = done && apb_req.pwrite && mapped;
  assign rd_done = done && !apb_req.pwrite && mapped;
  assign idx     = apb_req.paddr[ADDR_W-1:2];
  assign aligned = (apb_req.paddr[1:0] == 2'h0);
  assign mapped  = aligned && is_reg(idx);

  // detection terms
  assign edge_mode = type_vec(ctrl_q);
  assign fall_hit  = pin_prev_q & ~pin_q & neg_en_q;
  assign rise_hit  = ~pin_prev_q & pin_q & pos_en_q;
  assign edge_hit  = (fall_hit | rise_hit) & edge_mode &
                     {8{pin_valid_q}};
  assign level_hit = ((~pin_q & neg_en_q) | (pin_q & pos_en_q)) &
                     ~edge_mode;

  // channel flags
  always_comb begin
    for (int n = 0; n < CH_N; n++) begin
      if (edge_mode[n]) begin
        flag_d[n] = flag_q[n];
        if (wr_done && idx == IDX_FLAGS) begin
          flag_d[n] = apb_req.pwdata[n];
        end
        if (edge_hit[n]) begin
          flag_d[n] = 1'b1;
        end
      end else begin
        flag_d[n] = ~pin_q[n];
      end
    end
  end

  // read mux
  always_comb begin
    rd_byte = RST_BYTE;
    unique case (idx)
      IDX_CTRL:     rd_byte = ctrl_q;
      IDX_NEG_EN:   rd_byte = neg_en_q;
      IDX_POS_EN:   rd_byte = pos_en_q;
      IDX_FLAGS:    rd_byte = flag_q;
      IDX_IRQ_STAT: rd_byte = irq_stat_q;
      IDX_IRQ_MASK: rd_byte = irq_mask_q;
      default:      rd_byte = RST_BYTE;
    endcase
  end

  // pin sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q       <= RST_BYTE;
      pin_prev_q  <= RST_BYTE;
      pin_seen_q  <= 1'b0;
      pin_valid_q <= 1'b0;
    end else begin
      pin_q       <= port_mux(ctrl_q.source_port_select, port0_pins,
                              port1_pins, port2_pins, port3_pins);
      pin_prev_q  <= pin_q;
      // edges only once both samples are real
      pin_seen_q  <= 1'b1;
      pin_valid_q <= pin_seen_q;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= RST_BYTE;
      neg_en_q <= RST_BYTE;
      pos_en_q <= RST_BYTE;
    end else if (wr_done) begin
      if (idx == IDX_CTRL) begin
        ctrl_q <= apb_req.pwdata[7:0];
      end
      if (idx == IDX_NEG_EN) begin
        neg_en_q <= apb_req.pwdata[7:0];
      end
      if (idx == IDX_POS_EN) begin
        pos_en_q <= apb_req.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q    <= RST_BYTE;
      pin_irq_q <= 1'b0;
    end else begin
      flag_q    <= flag_d;
      pin_irq_q <= |flag_d;
    end
  end

  // sticky status, cleared by read, new event wins
  // only bits the read returned are cleared, so no event is lost
  assign stat_hit = edge_hit | level_hit;

  always_comb begin
    irq_stat_d = irq_stat_q | stat_hit;
    irq_mask_d = irq_mask_q;
    if (rd_done && idx == IDX_IRQ_STAT) begin
      irq_stat_d = (irq_stat_q & ~prdata_q[7:0]) | stat_hit;
    end
    if (wr_done && idx == IDX_IRQ_MASK) begin
      irq_mask_d = apb_req.pwdata[7:0];
    end
  end

  // irq tracks status and mask in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= RST_BYTE;
      irq_mask_q <= RST_BYTE;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q && !apb_req.pwrite && mapped) begin
        prdata_q <= {{(DATA_W-8){1'b0}}, rd_byte};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign pin_irq = pin_irq_q;
  assign irq     = irq_q;

  // checks
  chk_port_sample: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_q == port_mux($past(ctrl_q.source_port_select),
      $past(port0_pins), $past(port1_pins), $past(port2_pins),
      $past(port3_pins)))
    else $error("pin sample not from selected port");

  chk_level_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((flag_q ^ ~$past(pin_q)) & ~$past(edge_mode)) == 8'h00)
    else $error("level flag not inverse of pin");

  chk_fall_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fall_hit & edge_mode) != 8'h00 && pin_valid_q |=>
      ($past(fall_hit & edge_mode) & ~flag_q) == 8'h00)
    else $error("falling edge did not set flag");

  chk_rise_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rise_hit & edge_mode) != 8'h00 && pin_valid_q |=>
      ($past(rise_hit & edge_mode) & ~flag_q) == 8'h00)
    else $error("rising edge did not set flag");

  chk_edge_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_done && idx == IDX_FLAGS) |=>
      ($past(flag_q & edge_mode) & edge_mode & ~flag_q) == 8'h00)
    else $error("edge flag dropped without write");

  chk_edge_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_done && idx == IDX_FLAGS) |=>
      (flag_q & ~$past(flag_q) & $past(edge_mode) &
       ~$past(edge_hit)) == 8'h00)
    else $error("edge flag set without enabled edge");

  chk_pin_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_irq_q == (flag_q != 8'h00))
    else $error("pin interrupt disagrees with flags");

  chk_cfg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_q != $past(ctrl_q) |-> $past(wr_done && idx == IDX_CTRL))
    else $error("control changed without write");

  chk_apb_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  chk_irq_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_q == ((irq_stat_q & irq_mask_q) != 8'h00))
    else $error("irq disagrees with unmasked status");

  chk_pin_history: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_prev_q == $past(pin_q))
    else $error("previous pin sample not kept");

  chk_flag_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && idx == IDX_FLAGS |=>
      ((flag_q ^ $past(apb_req.pwdata[7:0])) & $past(edge_mode) &
       ~$past(edge_hit)) == 8'h00)
    else $error("edge flag did not take written value");

  chk_neg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_en_q != $past(neg_en_q) |-> $past(wr_done && idx == IDX_NEG_EN))
    else $error("negative enable changed without write");

  chk_pos_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    pos_en_q != $past(pos_en_q) |-> $past(wr_done && idx == IDX_POS_EN))
    else $error("positive enable changed without write");

  chk_stat_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(rd_done && idx == IDX_IRQ_STAT) |=>
      ($past(irq_stat_q) & ~irq_stat_q) == 8'h00)
    else $error("status bit dropped without read");

  chk_stat_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_done && idx == IDX_IRQ_STAT |=>
      (irq_stat_q & $past(prdata_q[7:0] & ~stat_hit)) == 8'h00)
    else $error("status read did not clear bits");

  chk_mask_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_mask_q != $past(irq_mask_q) |-> $past(wr_done && idx == IDX_IRQ_MASK))
    else $error("mask changed without write");

  chk_slverr_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr_q |-> pready_q)
    else $error("error response without ready");

  chk_rdata_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready_q |-> prdata_q == '0)
    else $error("read data not zero outside answer");

endmodule

// file: verilog/pin_irq_pkg.sv
// constants and types of the pin change interrupt unit
// Operation
// - two-bit source port select picks port 0, 1, 2 or 3
// - one type bit serves channels 6 and 7, another 4 and 5
// - channels 0 to 3 each have their own type bit, 1 means edge
// - negative enable arms low level or falling edge per channel
// - positive enable arms high level or rising edge per channel
// - in edge mode hardware sets the flag on an enabled edge
// - edge flag stays set until software clears it
// - in level mode the flag shows the inverted pin level
// - level mode flag ignores writes, edge mode flag is writable
// - control register resets to zero: port 0, all level mode
// - both polarity enable registers reset to zero
package pin_irq_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int CH_N   = 8;

  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'he9;
  localparam logic [7:0] IDX_NEG_EN    = 8'hea;
  localparam logic [7:0] IDX_POS_EN    = 8'heb;
  localparam logic [7:0] IDX_FLAGS     = 8'hec;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hf8;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hf9;

  // field positions in the control register
  localparam int POS_TYPE_CH6_CH7 = 7;
  localparam int POS_TYPE_CH4_CH5 = 6;
  localparam int POS_TYPE_CH3     = 5;
  localparam int POS_TYPE_CH0     = 2;
  localparam int POS_PORT_SEL     = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic       type_sel_ch6_ch7;
    logic       type_sel_ch4_ch5;
    logic [3:0] type_sel_ch3_ch0;
    logic [1:0] source_port_select;
  } pin_irq_type_port_ctrl_s;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

endpackage
